//--- hw/vitc_consts.vh
// constants for the vectored interrupt and trap controller
// assumes one 25 MHz system clock and a 16-bit word register port
`ifndef VITC_CONSTS_VH
`define VITC_CONSTS_VH

// ============================================================
// register indices on the 6-bit register port
`define VITC_A_GCTL1        6'h00
`define VITC_A_GCTL2        6'h01
`define VITC_A_FLAG0        6'h02
`define VITC_A_FLAG5        6'h07
`define VITC_A_EN0          6'h08
`define VITC_A_EN5          6'h0d
`define VITC_A_PRIO0        6'h0e
`define VITC_A_PRIO21       6'h23
`define VITC_A_TEST         6'h24
`define VITC_A_STATUS       6'h25
`define VITC_A_CORE         6'h26
`define VITC_A_IRQ_ST       6'h27
`define VITC_A_IRQ_MSK      6'h28

// ============================================================
// field positions
`define VITC_B_NEST_DIS     15
`define VITC_B_ALT_TABLE    15
`define VITC_B_LVL_TOP      3
`define VITC_F_LVL_LOW      7:5
`define VITC_F_TRAPS        4:1
`define VITC_F_EDGE_POL     2:0
`define VITC_B_TEST_TRAP    7

// ============================================================
// source map and sizes
`define VITC_NSRC           96
`define VITC_NPRIO          24
`define VITC_IMPL_MASK      96'h0040_210e_4006_22e3_fe1f_3fef
`define VITC_VEC_EXT0       0
`define VITC_VEC_EXT1       20
`define VITC_VEC_EXT2       29

// ============================================================
// vector table bases and levels
`define VITC_TRAP_BASE      24'h000004
`define VITC_USER_BASE      24'h000014
`define VITC_ALT_OFFSET     24'h000100
`define VITC_LVL_MASK_ALL   4'h7
`define VITC_LVL_OSC        4'hf
`define VITC_LVL_ADDR       4'he
`define VITC_LVL_STACK      4'hd
`define VITC_LVL_MATH       4'hc
`define VITC_PRIO_RESET     3'h0
`define VITC_RESET_WORD     16'h0000

`endif

//--- hw/vitc_ctrl.v
// vectored interrupt and trap controller: flags, enables, priorities,
// cpu level, arbitration and the request handshake toward the core
// assumes peripheral events and core strobes are on i_sys_clk;
// external request pins are asynchronous and get synchronised here
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "vitc_consts.vh"

module vitc_ctrl
(
    input  wire        i_sys_clk,         // system clock
    input  wire        i_reset_n,         // async reset, active low
    input  wire [5:0]  i_addr,            // register index
    input  wire [15:0] i_wdata,           // write data
    input  wire        i_wr,              // write strobe
    input  wire        i_rd,              // read strobe
    output reg  [15:0] o_rdata,           // read data, cycle after i_rd
    input  wire [95:0] i_periph_event,    // peripheral event pulses
    input  wire [2:0]  i_ext_pin,         // external request pins
    input  wire [3:0]  i_trap_event,      // math, addr, stack, osc
    input  wire        i_ack,             // core takes the request
    input  wire        i_restore,         // core returns from handler
    input  wire [3:0]  i_restore_level,   // level restored by the core
    output reg         o_req,             // request to the core
    output reg         o_req_trap,        // request is a trap
    output reg  [6:0]  o_req_vector,      // vector number
    output reg  [3:0]  o_req_level,       // level the core will run at
    output reg  [23:0] o_vector_addr,     // table entry to fetch
    output reg  [3:0]  o_cpu_level,       // current cpu level
    output reg         o_irq              // summary interrupt level
);

    // ============================================================
    // state
    reg  [95:0] flag;                      // request flags
    reg  [95:0] enable;                    // enable bits
    reg  [2:0]  prio [0:95];               // per-source priority
    reg         nesting_disable;           // control one bit 15
    reg  [3:0]  trap_flag;                 // osc, stack, addr, math
    reg  [2:0]  edge_pol;                  // 1 = falling edge
    reg         alt_table;                 // use alternate table
    reg  [2:0]  cpu_level_low_bits;        // status register level
    reg         cpu_level_top_bit;         // core control level bit
    reg  [11:0] test_reg;                  // latched vector and level
    reg  [2:0]  irq_status;                // sticky events
    reg  [2:0]  irq_mask;                  // event mask
    reg  [2:0]  pin_meta;                  // sync stage one
    reg  [2:0]  pin_sync;                  // sync stage two
    reg  [2:0]  pin_prev;                  // for edge detection

    wire [3:0]  cpu_level;                 // full four-bit level
    wire [2:0]  pin_edge;                  // detected external edges
    wire [95:0] event_set;                 // all flag set pulses
    wire [95:0] pend;                      // qualified requests
    wire [24*16-1:0] prio_flat;            // priority words for read

    assign cpu_level = {cpu_level_top_bit, cpu_level_low_bits};

    // ============================================================
    // external pins: two flops, then edge on chosen polarity
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            pin_prev <= 3'h0;
        end
        else
        begin
            pin_meta <= i_ext_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_edge = (edge_pol & pin_prev & ~pin_sync)
                    | (~edge_pol & ~pin_prev & pin_sync);

    // pins land on their own vectors; unimplemented sources drop
    assign event_set = (i_periph_event
                     | ({95'h0, pin_edge[0]} << `VITC_VEC_EXT0)
                     | ({95'h0, pin_edge[1]} << `VITC_VEC_EXT1)
                     | ({95'h0, pin_edge[2]} << `VITC_VEC_EXT2))
                     & `VITC_IMPL_MASK;

    // ============================================================
    // per-source flag, enable, priority storage
    genvar n;
    generate
        for (n = 0; n < `VITC_NSRC; n = n + 1)
        begin : g_src
            // word and field from vector number
            localparam integer WI = n / 16;
            localparam integer PI = n / 4;
            localparam [5:0] FA = `VITC_A_FLAG0 + WI[5:0];
            localparam [5:0] EA = `VITC_A_EN0 + WI[5:0];
            localparam [5:0] PA = `VITC_A_PRIO0 + PI[5:0];
            localparam integer BP = n % 16;
            localparam integer FP = 4 * (n % 4);
            localparam [95:0] IMP = `VITC_IMPL_MASK;

            always @(posedge i_sys_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    flag[n]   <= 1'b0;
                    enable[n] <= 1'b0;
                    prio[n]   <= `VITC_PRIO_RESET;
                end
                else if (IMP[n])
                begin
                    if (event_set[n])
                        flag[n] <= 1'b1;
                    else if (i_wr && i_addr == FA)
                        flag[n] <= i_wdata[BP];
                    if (i_wr && i_addr == EA)
                        enable[n] <= i_wdata[BP];
                    if (i_wr && i_addr == PA)
                        prio[n] <= i_wdata[FP+2:FP];
                end
            end

            assign pend[n] = flag[n] & enable[n] & ({1'b0, prio[n]} > cpu_level);
        end
    endgenerate

    // priority words assembled for readback; absent words read zero
    genvar p;
    generate
        for (p = 0; p < `VITC_NPRIO; p = p + 1)
        begin : g_pw
            assign prio_flat[16*p+15:16*p] = {1'b0, prio[4*p+3], 1'b0, prio[4*p+2],
                                              1'b0, prio[4*p+1], 1'b0, prio[4*p]};
        end
    endgenerate

    // ============================================================
    // arbitration: traps first, then user sources
    reg        next_req;                   // a candidate exists
    reg        next_trap;                  // candidate is a trap
    reg [6:0]  next_vec;                   // candidate vector
    reg [3:0]  next_lvl;                   // level once taken
    reg [2:0]  best_prio;                  // best user priority so far
    reg        best_found;                 // user candidate seen
    reg [23:0] next_addr;                  // table entry address
    integer    i;

    always @*
    begin
        next_req   = 1'b0;
        next_trap  = 1'b0;
        next_vec   = 7'h00;
        next_lvl   = 4'h0;
        best_prio  = 3'h0;
        best_found = 1'b0;
        // scan downward so ties go to lower vector
        for (i = `VITC_NSRC - 1; i >= 0; i = i - 1)
        begin
            if (pend[i] && (!best_found || prio[i] >= best_prio))
            begin
                best_found = 1'b1;
                best_prio  = prio[i];
                next_vec   = i[6:0];
            end
        end
        // level 7 already excludes all user sources
        if (best_found)
        begin
            next_req = 1'b1;
            next_lvl = nesting_disable ? `VITC_LVL_MASK_ALL : {1'b0, best_prio};
        end
        // traps outrank user requests; math is the lowest trap
        if (trap_flag[3] && `VITC_LVL_MATH > cpu_level)
        begin
            next_req  = 1'b1;
            next_trap = 1'b1;
            next_vec  = 7'h04;
            next_lvl  = `VITC_LVL_MATH;
        end
        // stack flag sits in bit one, address flag in bit two
        if (trap_flag[1] && `VITC_LVL_STACK > cpu_level)
        begin
            next_req  = 1'b1;
            next_trap = 1'b1;
            next_vec  = 7'h03;
            next_lvl  = `VITC_LVL_STACK;
        end
        if (trap_flag[2] && `VITC_LVL_ADDR > cpu_level)
        begin
            next_req  = 1'b1;
            next_trap = 1'b1;
            next_vec  = 7'h02;
            next_lvl  = `VITC_LVL_ADDR;
        end
        if (trap_flag[0] && `VITC_LVL_OSC > cpu_level)
        begin
            next_req  = 1'b1;
            next_trap = 1'b1;
            next_vec  = 7'h01;
            next_lvl  = `VITC_LVL_OSC;
        end
        // trap entries from the trap base
        // user entries at base plus twice vector
        next_addr = (next_trap ? `VITC_TRAP_BASE : `VITC_USER_BASE)
                  + {16'h0, next_vec, 1'b0}
                  + (alt_table ? `VITC_ALT_OFFSET : 24'h000000);
    end

    // taking is only legal against a standing request
    wire take = i_ack & o_req;

    // ============================================================
    // request outputs; dropped on take so a stale request never
    // survives the level change
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_req         <= 1'b0;
            o_req_trap    <= 1'b0;
            o_req_vector  <= 7'h00;
            o_req_level   <= 4'h0;
            o_vector_addr <= 24'h000000;
        end
        else
        begin
            o_req         <= next_req & ~take;
            o_req_trap    <= next_trap;
            o_req_vector  <= next_vec;
            o_req_level   <= next_lvl;
            o_vector_addr <= next_addr;
        end
    end

    // ============================================================
    // global controls, trap flags, cpu level, test register
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            nesting_disable    <= 1'b0;
            trap_flag          <= 4'h0;
            edge_pol           <= 3'h0;
            alt_table          <= 1'b0;
            cpu_level_low_bits <= 3'h0;
            cpu_level_top_bit  <= 1'b0;
            test_reg           <= 12'h000;
        end
        else
        begin
            if (i_wr && i_addr == `VITC_A_GCTL1)
            begin
                nesting_disable <= i_wdata[`VITC_B_NEST_DIS];
                trap_flag       <= i_wdata[`VITC_F_TRAPS] | i_trap_event;
            end
            else
                trap_flag <= trap_flag | i_trap_event;
            if (i_wr && i_addr == `VITC_A_GCTL2)
            begin
                edge_pol  <= i_wdata[`VITC_F_EDGE_POL];
                alt_table <= i_wdata[`VITC_B_ALT_TABLE];
            end
            // level: take beats restore beats software
            if (take)
            begin
                cpu_level_low_bits <= o_req_level[2:0];
                cpu_level_top_bit  <= o_req_level[3];
            end
            else if (i_restore)
            begin
                cpu_level_low_bits <= i_restore_level[2:0];
                cpu_level_top_bit  <= i_restore_level[3];
            end
            else
            begin
                if (i_wr && i_addr == `VITC_A_STATUS && !nesting_disable)
                    cpu_level_low_bits <= i_wdata[`VITC_F_LVL_LOW];
                // software may only clear top bit
                if (i_wr && i_addr == `VITC_A_CORE && !i_wdata[`VITC_B_LVL_TOP])
                    cpu_level_top_bit <= 1'b0;
            end
            if (take)
                test_reg <= {o_req_level, o_req_trap, o_req_vector};
        end
    end

    // ============================================================
    // sticky event status: taken, trap, pin edge; read clears
    wire [2:0] irq_event = {|pin_edge, |i_trap_event, take};

    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
            o_irq      <= 1'b0;
            o_cpu_level <= 4'h0;
        end
        else
        begin
            // set wins over the clearing read
            if (i_rd && i_addr == `VITC_A_IRQ_ST)
                irq_status <= irq_event;
            else
                irq_status <= irq_status | irq_event;
            if (i_wr && i_addr == `VITC_A_IRQ_MSK)
                irq_mask <= i_wdata[2:0];
            // one cycle behind the status bits
            o_irq       <= |(irq_status & irq_mask);
            o_cpu_level <= cpu_level;
        end
    end

    // ============================================================
    // read mux; unmapped and absent indices read zero
    reg [15:0] rd_word;                    // selected word
    integer    k;

    always @*
    begin
        rd_word = `VITC_RESET_WORD;
        case (i_addr)
            `VITC_A_GCTL1:   rd_word = {nesting_disable, 10'h000, trap_flag, 1'b0};
            `VITC_A_GCTL2:   rd_word = {alt_table, 12'h000, edge_pol};
            `VITC_A_TEST:    rd_word = {4'h0, test_reg};
            `VITC_A_STATUS:  rd_word = {8'h00, cpu_level_low_bits, 5'h00};
            `VITC_A_CORE:    rd_word = {12'h000, cpu_level_top_bit, 3'h0};
            `VITC_A_IRQ_ST:  rd_word = {13'h0000, irq_status};
            `VITC_A_IRQ_MSK: rd_word = {13'h0000, irq_mask};
            default:         rd_word = `VITC_RESET_WORD;
        endcase
        for (k = 0; k < 6; k = k + 1)
        begin
            if (i_addr == `VITC_A_FLAG0 + k[5:0])
                rd_word = flag[16*k +: 16];
            if (i_addr == `VITC_A_EN0 + k[5:0])
                rd_word = enable[16*k +: 16];
        end
        for (k = 0; k < 22; k = k + 1)
        begin
            if (i_addr == `VITC_A_PRIO0 + k[5:0])
                rd_word = prio_flat[16*k +: 16];
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= `VITC_RESET_WORD;
        else if (i_rd)
            o_rdata <= rd_word;
        else
            o_rdata <= `VITC_RESET_WORD;
    end

endmodule

//--- testbench/vitc_core_model.sv
// processor core model: takes presented requests after a delay
// assumes the request is a level that stands until taken
`timescale 1ns/10ps
module vitc_core_model
(
    input  wire       i_sys_clk,
    input  wire       i_reset_n,
    input  wire       i_req,      // request from controller
    input  wire       i_take_en,  // core accepts interrupts
    input  wire [3:0] i_delay,    // cycles before taking
    output reg        o_ack       // one-cycle take pulse
);
    reg [3:0] wait_cnt;           // cycles the request has stood
    // ============================================================
    // take a standing request; a slow core lets it wait a while
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ack    <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (o_ack)
        begin
            o_ack    <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (i_req && i_take_en)
        begin
            if (wait_cnt == i_delay)
                o_ack <= 1'b1;
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
        else
            wait_cnt <= 4'h0;
    end
endmodule

//--- testbench/vitc_ctrl_bench.sv
// self-checking bench for the interrupt controller
// assumes vitc_ctrl, its constants header and the core model
`timescale 1ns/10ps
`include "vitc_consts.vh"
module vitc_ctrl_bench;
    reg         i_sys_clk      = 1'b0;
    reg         i_reset_n      = 1'b0;
    reg  [5:0]  i_addr         = 6'h00;
    reg  [15:0] i_wdata        = 16'h0000;
    reg         i_wr           = 1'b0;
    reg         i_rd           = 1'b0;
    reg  [95:0] i_periph_event = 96'h0;
    reg  [2:0]  i_ext_pin      = 3'h0;
    reg  [3:0]  i_trap_event   = 4'h0;
    reg         take_en        = 1'b0;  // core accepts requests
    wire        ack;
    wire [15:0] o_rdata;
    wire        o_req;
    wire        o_req_trap;
    wire [6:0]  o_req_vector;
    wire [3:0]  o_req_level;
    wire [23:0] o_vector_addr;
    wire [3:0]  o_cpu_level;
    wire        o_irq;
    integer     n_errors  = 0;
    integer     cmp_count = 0;
    integer     k;
    always #20 i_sys_clk = ~i_sys_clk;  // 25 MHz
    // restore path is left idle: the bench core never returns
    vitc_ctrl u_vitc_ctrl (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_periph_event(i_periph_event), .i_ext_pin(i_ext_pin), .i_trap_event(i_trap_event),
        .i_ack(ack), .i_restore(1'b0), .i_restore_level(4'h0), .o_req(o_req),
        .o_req_trap(o_req_trap), .o_req_vector(o_req_vector), .o_req_level(o_req_level),
        .o_vector_addr(o_vector_addr), .o_cpu_level(o_cpu_level), .o_irq(o_irq));
    vitc_core_model u_vitc_core_model (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_req(o_req), .i_take_en(take_en), .i_delay(4'h2), .o_ack(ack));
    // ============================================================
    // helpers
    task print_verdict;
    begin
        $display("errors %0d of %0d compares", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input [23:0] got, input [23:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    end
    endtask
    task wr(input [5:0] a, input [15:0] d);
    begin
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
        #1;
    end
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input [5:0] a, input [15:0] exp);
    begin
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1;
        chk(o_rdata, exp);
    end
    endtask
    task idle(input integer n);
    begin
        repeat (n) @(posedge i_sys_clk);
        #1;
    end
    endtask
    task pulse(input [95:0] pv, input [3:0] tv);
    begin
        @(posedge i_sys_clk);
        i_periph_event <= pv;
        i_trap_event   <= tv;
        @(posedge i_sys_clk);
        i_periph_event <= 96'h0;
        i_trap_event   <= 4'h0;
        #1;
    end
    endtask
    // bounded wait for the request line to reach v
    task wait_req(input v);
        integer n;
    begin
        n = 0;
        while (o_req !== v && n < 16)
        begin
            @(posedge i_sys_clk);
            #1;
            n = n + 1;
        end
        if (o_req !== v)
        begin
            $display("CHECK FAILED t=%0t request wait ran out", $time);
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    endtask
    task req_chk(input trap, input [6:0] vec, input [3:0] lvl, input [23:0] adr);
    begin
        chk(o_req_trap, trap);
        chk(o_req_vector, vec);
        chk(o_req_level, lvl);
        chk(o_vector_addr, adr);
    end
    endtask
    // ============================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        for (k = 0; k < 64; k = k + 1)
            rd(k[5:0], 16'h0000);
        $display("test reset values done");
        wr(`VITC_A_PRIO0 + 6'h0d, 16'h7777);
        rd(`VITC_A_PRIO0 + 6'h0d, 16'h0000);
        wr(`VITC_A_PRIO0 + 6'h0c, 16'h7777);
        rd(`VITC_A_PRIO0 + 6'h0c, 16'h0770);
        wr(`VITC_A_PRIO0, 16'h7777);
        rd(`VITC_A_PRIO0, 16'h7777);
        $display("test priority map done");
        // event before enable: flag set, nothing forwarded
        wr(`VITC_A_PRIO0, 16'h5000);
        pulse(96'h8, 4'h0);
        idle(4);
        chk(o_req, 1'b0);
        wr(`VITC_A_EN0, 16'h0008);
        wait_req(1'b1);
        req_chk(1'b0, 7'h03, 4'h5, 24'h00001a);
        take_en = 1'b1;
        wait_req(1'b0);
        take_en = 1'b0;
        rd(`VITC_A_TEST, 16'h0503);
        rd(`VITC_A_STATUS, 16'h00a0);
        chk(o_cpu_level, 4'h5);
        idle(4);
        chk(o_req, 1'b0);
        rd(`VITC_A_FLAG0, 16'h0008);
        wr(`VITC_A_FLAG0, 16'h0000);
        wr(`VITC_A_IRQ_MSK, 16'h0001);
        idle(3);
        chk(o_irq, 1'b1);
        rd(`VITC_A_IRQ_ST, 16'h0001);
        idle(3);
        chk(o_irq, 1'b0);
        $display("test user take done");
        wr(`VITC_A_STATUS, 16'h0000);
        wr(`VITC_A_EN0 + 6'h01, 16'h0003);
        wr(`VITC_A_PRIO0 + 6'h04, 16'h0022);
        pulse(96'h3_0000, 4'h0);
        wait_req(1'b1);
        req_chk(1'b0, 7'h10, 4'h2, 24'h000034);
        wr(`VITC_A_PRIO0 + 6'h04, 16'h0032);
        idle(3);
        req_chk(1'b0, 7'h11, 4'h3, 24'h000036);
        wr(`VITC_A_GCTL2, 16'h8000);
        idle(3);
        chk(o_vector_addr, 24'h000136);
        wr(`VITC_A_PRIO0 + 6'h04, 16'h0072);
        wr(`VITC_A_STATUS, 16'h00c0);
        idle(3);
        req_chk(1'b0, 7'h11, 4'h7, 24'h000136);
        wr(`VITC_A_STATUS, 16'h00e0);
        idle(3);
        chk(o_req, 1'b0);
        wr(`VITC_A_GCTL1, 16'h8000);
        wr(`VITC_A_STATUS, 16'h0000);
        rd(`VITC_A_STATUS, 16'h00e0);
        rd(`VITC_A_GCTL1, 16'h8000);
        wr(`VITC_A_GCTL1, 16'h0000);
        wr(`VITC_A_GCTL2, 16'h0000);
        wr(`VITC_A_EN0 + 6'h01, 16'h0000);
        wr(`VITC_A_FLAG0 + 6'h01, 16'h0000);
        $display("test natural order done");
        // stack trap at level 7 still gets through
        pulse(96'h0, 4'h2);
        wait_req(1'b1);
        req_chk(1'b1, 7'h03, 4'hd, 24'h00000a);
        rd(`VITC_A_GCTL1, 16'h0004);
        take_en = 1'b1;
        wait_req(1'b0);
        take_en = 1'b0;
        wr(`VITC_A_GCTL1, 16'h0000);
        rd(`VITC_A_CORE, 16'h0008);
        rd(`VITC_A_TEST, 16'h0d83);
        rd(`VITC_A_STATUS, 16'h00a0);
        chk(o_cpu_level, 4'hd);
        wr(`VITC_A_CORE, 16'h0000);
        rd(`VITC_A_CORE, 16'h0000);
        chk(o_cpu_level, 4'h5);
        wr(`VITC_A_CORE, 16'h0008);
        rd(`VITC_A_CORE, 16'h0000);
        // address and stack traps together: address error ranks higher
        pulse(96'h0, 4'h6);
        wait_req(1'b1);
        req_chk(1'b1, 7'h02, 4'he, 24'h000008);
        rd(`VITC_A_GCTL1, 16'h000c);
        wr(`VITC_A_GCTL1, 16'h0000);
        $display("test trap take done");
        i_ext_pin <= 3'h1;
        idle(6);
        rd(`VITC_A_FLAG0, 16'h0001);
        // falling edge polarity on pin zero
        wr(`VITC_A_GCTL2, 16'h0001);
        wr(`VITC_A_FLAG0, 16'h0000);
        i_ext_pin <= 3'h0;
        idle(6);
        rd(`VITC_A_FLAG0, 16'h0001);
        $display("test pin edge done");
        print_verdict;
    end
endmodule

//--- testbench/vitc_ctrl_props.sv
// port checker for the interrupt controller
// assumes one clock domain; bound to every vitc_ctrl instance below
`timescale 1ns/10ps
module vitc_ctrl_props
(
    input wire        i_sys_clk,
    input wire        i_reset_n,
    input wire        i_rd,
    input wire        i_ack,
    input wire        i_restore,
    input wire [15:0] o_rdata,
    input wire        o_req,
    input wire        o_req_trap,
    input wire [6:0]  o_req_vector,
    input wire [3:0]  o_req_level,
    input wire [23:0] o_vector_addr,
    input wire [3:0]  o_cpu_level
);
    // ============================================================
    // helper terms
    wire        take      = o_req && i_ack;                 // request taken
    wire        trap_take = take && o_req_trap;             // trap taken
    wire [23:0] base_addr = o_vector_addr & 24'hfffeff;     // table select removed
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // ============================================================
    // assertions
    a_rdata_idle_zero: assert property (
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_user_level: assert property (
        o_req && !o_req_trap |-> o_req_level != 4'h0 && o_req_level <= 4'h7)
        else $error("user request level out of range");
    a_user_addr: assert property (
        o_req && !o_req_trap |-> base_addr == 24'h000014 + {16'h0000, o_req_vector, 1'b0})
        else $error("user vector address wrong");
    a_trap_addr: assert property (
        o_req && o_req_trap |-> base_addr == 24'h000004 + {16'h0000, o_req_vector, 1'b0})
        else $error("trap vector address wrong");
    a_trap_level: assert property (
        o_req && o_req_trap |-> {1'b0, o_req_level} + o_req_vector[4:0] == 5'h10)
        else $error("trap level does not match trap vector");
    a_ack_drops: assert property (
        take |=> !o_req)
        else $error("request still up after it was taken");
    a_ack_level: assert property (
        take |-> ##2 o_cpu_level == $past(o_req_level, 2))
        else $error("cpu level not loaded from taken request");
    a_top_bit_rise: assert property (
        $rose(o_cpu_level[3]) |-> $past(trap_take, 2) || $past(i_restore, 2))
        else $error("top level bit rose without trap or restore");
    a_user_below_trap: assert property (
        o_req && !o_req_trap |-> !o_cpu_level[3])
        else $error("user request while cpu level above seven");
    // ============================================================
    // covers
    c_user_take: cover property (take && !o_req_trap);
    c_trap_take: cover property (trap_take);
    c_read_data: cover property (i_rd ##1 o_rdata != 16'h0000);
endmodule

bind vitc_ctrl vitc_ctrl_props u_vitc_ctrl_props
(
    .i_sys_clk     (i_sys_clk),
    .i_reset_n     (i_reset_n),
    .i_rd          (i_rd),
    .i_ack         (i_ack),
    .i_restore     (i_restore),
    .o_rdata       (o_rdata),
    .o_req         (o_req),
    .o_req_trap    (o_req_trap),
    .o_req_vector  (o_req_vector),
    .o_req_level   (o_req_level),
    .o_vector_addr (o_vector_addr),
    .o_cpu_level   (o_cpu_level)
);
